/* bosm_defs.svh */
// Purpose: constants for the blade operational state manager
// Assumes: 50 MHz management clock
// Notes:   byte values and timing counts only
`ifndef BOSM_DEFS_SVH
`define BOSM_DEFS_SVH
`define BOSM_MARKER_BYTE    8'h02
`define BOSM_REVISION_BYTE  8'h10
`define BOSM_CC_OK          8'h00
`define BOSM_CC_BAD_REQ     8'hCC
`define BOSM_RESP_LEN       3'd5
`define BOSM_SECOND_NS      64'd1000000000
`define BOSM_CLK_NS         64'd20
`define BOSM_SECOND_CYCLES  (`BOSM_SECOND_NS / `BOSM_CLK_NS)
`endif

/* bosm_pkg.sv */
// Purpose: shared types for the blade operational state manager
// Assumes: nothing
// Notes:   state codes follow declaration order
`default_nettype none
package bosm_pkg;
  typedef enum logic [2:0] {
    BOSM_INACTIVE,
    BOSM_ACT_REQ,
    BOSM_ACT_PROG,
    BOSM_ACTIVE,
    BOSM_DEACT_REQ,
    BOSM_DEACT_PROG
  } bosm_state_t;
  typedef enum logic [1:0] {
    BOSM_CMD_NONE,
    BOSM_CMD_ACTIVATE,
    BOSM_CMD_DEACTIVATE
  } bosm_cmd_t;
endpackage : bosm_pkg
`default_nettype wire

/* bosm_props_resp.sv */
// Purpose: serialises the five-byte properties answer
// Assumes: request byte presented with a one-cycle strobe
// Notes:   a busy answer ignores new queries
`default_nettype none
`include "bosm_defs.svh"
module bosm_props_resp
  import bosm_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       enable_in,
  input  wire logic       query_in,
  input  wire logic [7:0] query_byte_in,
  input  wire logic [7:0] slot_count_in,
  input  wire logic [7:0] highest_module_index_in,
  output logic            resp_valid_out,
  output logic [7:0]      resp_byte_out,
  output logic            resp_last_out
);
  typedef struct packed {
    logic       busy;
    logic [2:0] idx;
    logic       bad;
    logic       vld;
    logic [7:0] data;
    logic       last;
  } bosm_resp_st_t;
  bosm_resp_st_t s_q, s_d;

  function automatic logic [7:0] resp_at(input logic [2:0] i, input logic bad,
                                         input logic [7:0] sc, input logic [7:0] hm);
    unique case (i)
      3'd0:    resp_at = bad ? `BOSM_CC_BAD_REQ : `BOSM_CC_OK;
      3'd1:    resp_at = `BOSM_MARKER_BYTE;
      3'd2:    resp_at = `BOSM_REVISION_BYTE;
      3'd3:    resp_at = sc;
      default: resp_at = hm;
    endcase
  endfunction : resp_at

  always_comb begin
    s_d     = s_q;
    s_d.vld = 1'b0;
    // last is a one-cycle mark, never left standing after the answer
    s_d.last = 1'b0;
    if (s_q.busy) begin
      s_d.vld  = 1'b1;
      s_d.data = resp_at(s_q.idx, s_q.bad, slot_count_in, highest_module_index_in);
      s_d.last = (s_q.idx == `BOSM_RESP_LEN - 3'd1) | s_q.bad;
      s_d.idx  = s_q.idx + 3'd1;
      if (s_d.last) s_d.busy = 1'b0;
    end else if (query_in) begin
      // wrong marker gets only a completion code
      s_d.busy = 1'b1;
      s_d.idx  = 3'd0;
      s_d.bad  = (query_byte_in != `BOSM_MARKER_BYTE);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) s_q <= '0;
    else if (enable_in) s_q <= s_d;
  end

  assign resp_valid_out = s_q.vld;
  assign resp_byte_out  = s_q.data;
  assign resp_last_out  = s_q.last;
endmodule : bosm_props_resp
`default_nettype wire

/* bosm_state_mgr.sv */
// Purpose: blade operational state manager top
// Assumes: commands are one-cycle pulses, inputs synchronous
// Notes:   event queue is one deep; a new change overwrites a pending one
`default_nettype none
`include "bosm_defs.svh"
module bosm_state_mgr
  import bosm_pkg::*;
#(
  parameter int SLOT_W         = 6,
  parameter int SECOND_CYCLES  = int'(`BOSM_SECOND_CYCLES)
) (
  input  wire logic              clock_in,
  input  wire logic              reset_n_in,
  input  wire logic              enable_in,
  input  wire logic [SLOT_W-1:0] slot_position_number_in,
  input  wire logic              query_in,
  input  wire logic [7:0]        query_byte_in,
  input  wire logic [7:0]        slot_count_in,
  input  wire logic [7:0]        highest_module_index_in,
  input  wire logic              cmd_valid_in,
  input  wire bosm_cmd_t         cmd_in,
  input  wire logic              set_policy_in,
  input  wire logic              policy_value_in,
  input  wire logic              button_press_in,
  input  wire logic              activation_ok_in,
  input  wire logic              deactivation_ok_in,
  input  wire logic              payload_power_good_in,
  input  wire logic              payload_power_fail_in,
  input  wire logic              payload_off_request_in,
  input  wire logic              deactivation_done_in,
  input  wire logic              event_ready_in,
  output logic                   resp_valid_out,
  output logic [7:0]             resp_byte_out,
  output logic                   resp_last_out,
  output logic                   event_valid_out,
  output bosm_state_t            event_state_out,
  output bosm_state_t            state_out,
  output logic                   policy_out,
  output logic                   payload_power_out,
  output logic                   startup_done_out
);
  // elaboration checks: the second counter and slot compare cannot serve other sizes
  if (SLOT_W < 1 || SLOT_W > 8) begin : g_bad_slot_w
    $error("slot width unsupported");
  end
  if (SECOND_CYCLES < 1) begin : g_bad_second
    $error("second count must be positive");
  end

  typedef struct packed {
    bosm_state_t state;
    logic        policy;
    logic        power;
    logic        started;
    logic [31:0] tick;
    logic [SLOT_W-1:0] secs;
    logic        ev_pend;
    bosm_state_t ev_state;
  } bosm_st_t;
  bosm_st_t s_q, s_d;

  logic cmd_act, cmd_deact, forced_off;

  // extraction criteria: deactivate policy plus local approval
  function automatic logic extraction_met(input logic policy, input logic ok);
    extraction_met = !policy && ok;
  endfunction : extraction_met

  // one decode serves both command kinds
  function automatic logic cmd_is(input logic vld, input bosm_cmd_t cmd, input bosm_cmd_t kind);
    cmd_is = vld && (cmd == kind);
  endfunction : cmd_is

  // payload stays up from active until deactivation finishes
  function automatic logic holds_power(input bosm_state_t nxt, input logic was_on, input logic done);
    holds_power = (nxt == BOSM_ACTIVE) || (nxt == BOSM_DEACT_REQ) ||
                  (nxt == BOSM_DEACT_PROG && was_on && !done);
  endfunction : holds_power

  // the answer path runs from reset, so queries are served during the wait
  bosm_props_resp u_props (
    .clock_in                (clock_in),
    .reset_n_in              (reset_n_in),
    .enable_in               (enable_in),
    .query_in                (query_in),
    .query_byte_in           (query_byte_in),
    .slot_count_in           (slot_count_in),
    .highest_module_index_in (highest_module_index_in),
    .resp_valid_out          (resp_valid_out),
    .resp_byte_out           (resp_byte_out),
    .resp_last_out           (resp_last_out)
  );

  always_comb begin
    cmd_act    = cmd_is(cmd_valid_in, cmd_in, BOSM_CMD_ACTIVATE);
    cmd_deact  = cmd_is(cmd_valid_in, cmd_in, BOSM_CMD_DEACTIVATE);
    // payload loss or a payload-initiated off forces deactivation from BOSM_ACTIVE or BOSM_DEACT_REQ
    forced_off = payload_power_fail_in | payload_off_request_in;
    s_d        = s_q;

    // startup wait: slot position times one second
    if (!s_q.started) begin
      if (s_q.secs == slot_position_number_in) begin
        s_d.started = 1'b1;
      end else if (s_q.tick == 32'(SECOND_CYCLES - 1)) begin
        s_d.tick = '0;
        s_d.secs = s_q.secs + SLOT_W'(1);
      end else begin
        s_d.tick = s_q.tick + 32'd1;
      end
    end

    // button toggles policy; explicit command wins when both arrive
    if (button_press_in) begin
      s_d.policy = ~s_q.policy;
    end
    if (set_policy_in) begin
      s_d.policy = policy_value_in;
    end

    // the not-present state lives only on the manager side
    unique case (s_q.state)
      BOSM_INACTIVE: begin
        // insertion criteria: activate policy and local readiness
        if (s_q.policy && activation_ok_in) begin
          s_d.state = BOSM_ACT_REQ;
        end
      end
      BOSM_ACT_REQ: begin
        if (cmd_act) begin
          s_d.state = BOSM_ACT_PROG;
        end else if (cmd_deact || extraction_met(s_q.policy, deactivation_ok_in)) begin
          // denial or extraction criteria drop the request
          s_d.state = BOSM_INACTIVE;
        end
      end
      BOSM_ACT_PROG: begin
        if (cmd_deact || payload_power_fail_in || extraction_met(s_q.policy, deactivation_ok_in)) begin
          s_d.state = BOSM_DEACT_PROG;
        end else if (payload_power_good_in) begin
          // autonomous move once payload rails are good
          s_d.state = BOSM_ACTIVE;
        end
      end
      BOSM_ACTIVE: begin
        if (cmd_deact || forced_off) begin
          s_d.state = BOSM_DEACT_PROG;
        end else if (extraction_met(s_q.policy, deactivation_ok_in)) begin
          s_d.state = BOSM_DEACT_REQ;
        end
      end
      BOSM_DEACT_REQ: begin
        // manager approves with deactivate, denies with activate
        if (cmd_deact || forced_off) begin
          s_d.state = BOSM_DEACT_PROG;
        end else if (cmd_act) begin
          s_d.state = BOSM_ACTIVE;
        end
      end
      BOSM_DEACT_PROG: begin
        // no way back once deactivation has started
        if (deactivation_done_in) begin
          s_d.state  = BOSM_INACTIVE;
          s_d.policy = 1'b0;
        end
      end
    endcase

    s_d.power = holds_power(s_d.state, s_q.power, deactivation_done_in);

    // event handshake; held back until the startup wait ends
    if (s_q.ev_pend && event_ready_in && s_q.started) begin
      s_d.ev_pend = 1'b0;
    end
    // a fresh change wins over the clear, so the newest state is always reported
    if (s_d.state != s_q.state) begin
      s_d.ev_pend  = 1'b1;
      s_d.ev_state = s_d.state;
    end
  end

  // enable low freezes every field, the startup timer included
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else if (enable_in) begin
      s_q <= s_d;
    end
  end

  assign event_valid_out   = s_q.ev_pend & s_q.started;
  assign event_state_out   = s_q.ev_state;
  assign state_out         = s_q.state;
  assign policy_out        = s_q.policy;
  assign payload_power_out = s_q.power;
  assign startup_done_out  = s_q.started;
endmodule : bosm_state_mgr
`default_nettype wire

/* bosm_state_mgr_monitor.sv */
// Purpose: port assertions for the blade state manager
// Assumes: enable held high
// Notes:   answer order checked from the leading 00h byte
`default_nettype none
module bosm_state_mgr_monitor
  import bosm_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input wire logic        cmd_valid_in,
  input wire bosm_cmd_t   cmd_in,
  input wire logic        deactivation_ok_in,
  input wire logic        deactivation_done_in,
  input wire logic        event_ready_in,
  input wire logic [7:0]  highest_module_index_in,
  input wire logic        resp_valid_out,
  input wire logic [7:0]  resp_byte_out,
  input wire logic        resp_last_out,
  input wire logic        event_valid_out,
  input wire bosm_state_t event_state_out,
  input wire bosm_state_t state_out,
  input wire logic        policy_out,
  input wire logic        payload_power_fail_in,
  input wire logic        payload_off_request_in,
  input wire logic        startup_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_answer;
    resp_byte_out == 8'h02 ##1 resp_byte_out == 8'h10;
  endsequence
  answer_order_a: assert property ($rose(resp_valid_out) && resp_byte_out == 8'h00 |=> s_answer)
    else $error("answer byte order wrong");
  last_byte_a: assert property (resp_last_out && $past(resp_valid_out) |->
    resp_byte_out == highest_module_index_in) else $error("last byte wrong");
  event_report_a: assert property ($changed(state_out) && $past(reset_n_in) |->
    !startup_done_out || (event_valid_out && event_state_out == state_out)) else $error("change not reported");
  event_hold_a: assert property (event_valid_out && !event_ready_in |=> event_valid_out)
    else $error("event dropped");
  act_cmd_a: assert property (state_out == BOSM_ACT_REQ && cmd_valid_in && cmd_in == BOSM_CMD_ACTIVATE
    |=> state_out == BOSM_ACT_PROG) else $error("activate ignored");
  deact_cmd_a: assert property (state_out == BOSM_DEACT_REQ && cmd_valid_in && cmd_in == BOSM_CMD_DEACTIVATE
    |=> state_out == BOSM_DEACT_PROG) else $error("deactivate ignored");
  policy_exit_a: assert property (state_out == BOSM_ACTIVE && !policy_out && deactivation_ok_in && !cmd_valid_in
    && !payload_power_fail_in && !payload_off_request_in
    |=> state_out == BOSM_DEACT_REQ) else $error("policy exit missed");
  revoke_a: assert property (state_out == BOSM_DEACT_PROG && deactivation_done_in
    |=> state_out == BOSM_INACTIVE && !policy_out) else $error("deactivation end wrong");
  forced_off_a: assert property ((state_out == BOSM_ACTIVE || state_out == BOSM_DEACT_REQ)
    && (payload_power_fail_in || payload_off_request_in) |=> state_out == BOSM_DEACT_PROG)
    else $error("forced deactivation missed");
endmodule : bosm_state_mgr_monitor
bind bosm_state_mgr bosm_state_mgr_monitor mon (.*);
`default_nettype wire

/* bosm_mgr_model.sv */
// Purpose: chassis manager model taking state events
// Assumes: slow mode accepts every other cycle
// Notes:   keeps its own copy of the blade state
`default_nettype none
module bosm_mgr_model
  import bosm_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic         slow_in,
  input  wire logic         event_valid_in,
  input  wire bosm_state_t  event_state_in,
  output logic              event_ready_out,
  output bosm_state_t       mirror_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tgl_q;
  assign event_ready_out = !slow_in || tgl_q;
  always_ff @(posedge clock_in) begin
    tgl_q <= reset_n_in && !tgl_q;
    if (!reset_n_in) mirror_out <= BOSM_INACTIVE;
    else if (event_valid_in && event_ready_out) mirror_out <= event_state_in;
  end
endmodule : bosm_mgr_model
`default_nettype wire

/* bosm_state_mgr_tb.sv */
// Purpose: self-checking bench for the blade state manager
// Assumes: slot 1, one second cut to 10 cycles
// Notes:   enable held high; payload faults driven in late scenarios
`default_nettype none
module bosm_state_mgr_tb
  import bosm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0, reset_n_in = 1'b0, query_in = 1'b0, cmd_valid_in = 1'b0, slow = 1'b0;
  logic set_policy_in = 1'b0, policy_value_in = 1'b0, button_press_in = 1'b0, payload_power_good_in = 1'b0;
  logic activation_ok_in = 1'b0, deactivation_ok_in = 1'b0, deactivation_done_in = 1'b0, event_ready_in;
  logic payload_power_fail_in = 1'b0, payload_off_request_in = 1'b0;
  logic [7:0] query_byte_in = 8'h02, slot_count_in = 8'h03, highest_module_index_in = 8'h07;
  logic [7:0] resp_byte_out, exp_q[$];
  logic resp_valid_out, resp_last_out, event_valid_out, policy_out, payload_power_out, startup_done_out;
  bosm_cmd_t   cmd_in = BOSM_CMD_NONE;
  bosm_state_t event_state_out, state_out, mirror;
  int          n_mismatch = 0, checks_done = 0;
  always #10 clock_in = ~clock_in;
  bosm_state_mgr #(.SLOT_W(6), .SECOND_CYCLES(10)) dut (.enable_in(1'b1), .slot_position_number_in(6'h01), .*);
  bosm_mgr_model mgr (.clock_in, .reset_n_in, .slow_in(slow), .event_valid_in(event_valid_out),
    .event_state_in(event_state_out), .event_ready_out(event_ready_in), .mirror_out(mirror));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_in);
  endtask : tick
  task automatic check(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic cmd(input bosm_cmd_t c);
    cmd_in <= c;
    cmd_valid_in <= 1'b1;
    tick();
    cmd_valid_in <= 1'b0;
  endtask : cmd
  task automatic set_pol(input logic v);
    policy_value_in <= v;
    set_policy_in <= 1'b1;
    tick();
    set_policy_in <= 1'b0;
  endtask : set_pol
  task automatic press();
    button_press_in <= 1'b1;
    tick();
    button_press_in <= 1'b0;
  endtask : press
  // blade state and manager copy must agree once the event lands
  task automatic expect_st(input bosm_state_t s);
    tick(4);
    check(8'(s), 8'(state_out));
    check(8'(s), 8'(mirror));
  endtask : expect_st
  task automatic query(input logic [7:0] b);
    logic [7:0] got[$];
    int         n_last = 0;
    int         last_at = 0;
    query_byte_in <= b;
    query_in <= 1'b1;
    tick();
    query_in <= 1'b0;
    repeat (8) begin
      tick();
      if (resp_valid_out === 1'b1) got.push_back(resp_byte_out);
      if (resp_last_out === 1'b1) n_last++;
      if (resp_valid_out === 1'b1 && resp_last_out === 1'b1) last_at = got.size();
    end
    check(8'(exp_q.size()), 8'(got.size()));
    foreach (exp_q[i]) check(exp_q[i], got[i]);
    check(8'h01, 8'(n_last));
    check(8'(exp_q.size()), 8'(last_at));
  endtask : query
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  initial begin
    tick(3000);
    n_mismatch++;
    final_report();
  end
  initial begin
    tick(2);
    reset_n_in <= 1'b1;
    set_pol(1'b1);
    tick(2);
    check(8'h01, 8'(policy_out));
    check(8'h00, 8'(startup_done_out));
    exp_q = '{8'h00, 8'h02, 8'h10, 8'h03, 8'h07};
    query(8'h02);
    exp_q = '{8'hCC};
    query(8'h55);
    repeat (40) if (startup_done_out !== 1'b1) tick();
    check(8'h01, 8'(startup_done_out));
    activation_ok_in <= 1'b1;
    expect_st(BOSM_ACT_REQ);
    cmd(BOSM_CMD_ACTIVATE);
    expect_st(BOSM_ACT_PROG);
    payload_power_good_in <= 1'b1;
    expect_st(BOSM_ACTIVE);
    check(8'h01, 8'(payload_power_out));
    slow <= 1'b1;
    deactivation_ok_in <= 1'b1;
    set_pol(1'b0);
    expect_st(BOSM_DEACT_REQ);
    deactivation_ok_in <= 1'b0;
    cmd(BOSM_CMD_ACTIVATE);
    expect_st(BOSM_ACTIVE);
    press();
    tick(2);
    check(8'h01, 8'(policy_out));
    deactivation_ok_in <= 1'b1;
    press();
    expect_st(BOSM_DEACT_REQ);
    cmd(BOSM_CMD_DEACTIVATE);
    expect_st(BOSM_DEACT_PROG);
    payload_power_good_in <= 1'b0;
    deactivation_done_in <= 1'b1;
    expect_st(BOSM_INACTIVE);
    deactivation_done_in <= 1'b0;
    check(8'h00, 8'(policy_out));
    check(8'h00, 8'(payload_power_out));
    set_pol(1'b1);
    expect_st(BOSM_ACT_REQ);
    cmd(BOSM_CMD_ACTIVATE);
    expect_st(BOSM_ACT_PROG);
    set_pol(1'b0);
    expect_st(BOSM_DEACT_PROG);
    deactivation_done_in <= 1'b1;
    expect_st(BOSM_INACTIVE);
    deactivation_done_in <= 1'b0;
    set_pol(1'b1);
    expect_st(BOSM_ACT_REQ);
    cmd(BOSM_CMD_ACTIVATE);
    expect_st(BOSM_ACT_PROG);
    payload_power_fail_in <= 1'b1;
    expect_st(BOSM_DEACT_PROG);
    payload_power_fail_in <= 1'b0;
    check(8'h00, 8'(payload_power_out));
    deactivation_done_in <= 1'b1;
    expect_st(BOSM_INACTIVE);
    deactivation_done_in <= 1'b0;
    set_pol(1'b1);
    expect_st(BOSM_ACT_REQ);
    cmd(BOSM_CMD_ACTIVATE);
    expect_st(BOSM_ACT_PROG);
    payload_power_good_in <= 1'b1;
    expect_st(BOSM_ACTIVE);
    payload_off_request_in <= 1'b1;
    expect_st(BOSM_DEACT_PROG);
    payload_off_request_in <= 1'b0;
    check(8'h01, 8'(payload_power_out));
    deactivation_done_in <= 1'b1;
    expect_st(BOSM_INACTIVE);
    deactivation_done_in <= 1'b0;
    set_pol(1'b1);
    expect_st(BOSM_ACT_REQ);
    activation_ok_in <= 1'b0;
    cmd(BOSM_CMD_DEACTIVATE);
    expect_st(BOSM_INACTIVE);
    final_report();
  end
endmodule : bosm_state_mgr_tb
`default_nettype wire
